// ===== dtc_defines.svh
// dual timer/counter: bit positions, reset values and divider figure
// assumes the includer knows the mode register layout of two nibbles
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// mode register fields, timer 0 in the low nibble, timer 1 in the high
`define DTC_T0_MODE_LSB   0
`define DTC_T0_SRC_BIT    2
`define DTC_T0_GATE_BIT   3
`define DTC_T1_MODE_LSB   4
`define DTC_T1_SRC_BIT    6
`define DTC_T1_GATE_BIT   7

// system clock divided by this in standard timer function
`define DTC_PRESCALE      12

`define DTC_BYTE_RESET    8'h00
`define DTC_FLAG_RESET    1'b0
// toggle output idles high until the first overflow
`define DTC_TOGGLE_RESET  1'b1

`endif

// ===== dtc_pin_model.sv
// dual timer/counter: far-side model of one shared count/toggle pin
// assumes a pull-up on the pin and a device enable that is high while driving
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire logic clk,
    input  wire logic dev_out,
    input  wire logic dev_oe,
    output logic      pin
);
    logic ext_level;
    // released pin floats to the pull-up level
    assign pin = dev_oe ? dev_out : ext_level;
    initial ext_level = 1'b1;
    // each level lasts several clocks so one sample sees high, the next low
    task automatic falls(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_level <= 1'b0;
            repeat (3) @(posedge clk);
            ext_level <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// ===== dtc_pin_sync.sv
// dual timer/counter: two-flop synchroniser with falling-edge detect
// assumes an asynchronous pin and one system clock
`timescale 1ns/1ps
module dtc_pin_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      fall
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    always_comb begin
        meta_d = pin;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // high in one sample, low in the next
    assign level = sync_q;
    assign fall  = prev_q & ~sync_q; // RULE_04
endmodule

// ===== dtc_pkg.sv
// dual timer/counter: shared types
// assumes nothing beyond a SystemVerilog compiler
package dtc_pkg;
    // declaration order gives the field encodings 00, 01, 10, 11
    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_RELOAD8,
        DTC_MODE_SPLIT
    } dtc_mode_t;
endpackage

// ===== dtc_timer.sv
// dual timer/counter: two 8051-style timers with four modes each
// assumes software strobes come from logic on SYS_CLK, pins are asynchronous
//
// How it works
// RULE_01: two timers, each high and low byte
// RULE_02: source select bits pick timer or counter
// RULE_03: clock divided by twelve or undivided
// RULE_04: count pin falling edge from two samples
// RULE_05: toggle count pin on each overflow
// RULE_06: toggle output high before first overflow
// RULE_07: toggle only when counting system clock
// RULE_08: software stops timer before byte access
// RULE_09: mode 0 counts thirteen bits, upper ignored
// RULE_10: count needs run and gate or pin
// RULE_11: thirteen-bit rollover sets overflow flag
// RULE_12: sixteen-bit rollover sets overflow flag
// RULE_13: mode 2 reloads low from high byte
// RULE_14: only timer 1 overflow feeds baud
// RULE_15: timer 1 mode 3 freezes count
// RULE_16: split low byte uses timer 0 controls
// RULE_17: split high byte uses timer 1 run, flag
// RULE_18: timer 1 ignores run, flag during split
// RULE_19: timer 1 keeps gate, pin, divide
// RULE_20: mode field encodes four modes
// RULE_21: flag cleared on service entry or software
// RULE_22: clearing run holds both bytes
// RULE_23: flag drives a level interrupt request
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_timer #(
    parameter int PRESCALE = `DTC_PRESCALE
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic [7:0] TIMER_MODE_REGISTER,
    input  wire logic       TIMER0_RUN_BIT,
    input  wire logic       TIMER1_RUN_BIT,
    input  wire logic       TIMER0_CLOCK_DIVIDE_SELECT,
    input  wire logic       TIMER1_CLOCK_DIVIDE_SELECT,
    input  wire logic       TIMER0_TOGGLE_OUTPUT_ENABLE,
    input  wire logic       TIMER1_TOGGLE_OUTPUT_ENABLE,
    input  wire logic [7:0] WRITE_DATA,
    input  wire logic       WRITE_TIMER0_HIGH_BYTE,
    input  wire logic       WRITE_TIMER0_LOW_BYTE,
    input  wire logic       WRITE_TIMER1_HIGH_BYTE,
    input  wire logic       WRITE_TIMER1_LOW_BYTE,
    input  wire logic       TIMER0_FLAG_SET,
    input  wire logic       TIMER0_FLAG_CLEAR,
    input  wire logic       TIMER0_SERVICE_ENTRY,
    input  wire logic       TIMER1_FLAG_SET,
    input  wire logic       TIMER1_FLAG_CLEAR,
    input  wire logic       TIMER1_SERVICE_ENTRY,
    input  wire logic       TIMER0_COUNT_PIN_IN,
    input  wire logic       TIMER1_COUNT_PIN_IN,
    input  wire logic       GATE_PIN_ZERO,
    input  wire logic       GATE_PIN_ONE,
    output logic [7:0]      TIMER0_HIGH_BYTE,
    output logic [7:0]      TIMER0_LOW_BYTE,
    output logic [7:0]      TIMER1_HIGH_BYTE,
    output logic [7:0]      TIMER1_LOW_BYTE,
    output logic            TIMER0_OVERFLOW_FLAG,
    output logic            TIMER1_OVERFLOW_FLAG,
    output logic            TIMER0_IRQ,
    output logic            TIMER1_IRQ,
    output logic            BAUD_TICK,
    output logic            TIMER0_COUNT_PIN_OUT,
    output logic            TIMER0_COUNT_PIN_OE,
    output logic            TIMER1_COUNT_PIN_OUT,
    output logic            TIMER1_COUNT_PIN_OE
);
    localparam int PW = (PRESCALE > 2) ? $clog2(PRESCALE) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

    // elaboration check: the prescaler compare needs at least two states
    if (PRESCALE < 2) begin : g_prescale_check
        $error("PRESCALE must be at least 2");
    end

    // field decode
    dtc_pkg::dtc_mode_t mode0;
    dtc_pkg::dtc_mode_t mode1;
    logic src0, src1, gate0, gate1;

    always_comb begin
        mode0 = dtc_pkg::dtc_mode_t'(TIMER_MODE_REGISTER[`DTC_T0_MODE_LSB +: 2]); // RULE_20
        mode1 = dtc_pkg::dtc_mode_t'(TIMER_MODE_REGISTER[`DTC_T1_MODE_LSB +: 2]); // RULE_20
        src0  = TIMER_MODE_REGISTER[`DTC_T0_SRC_BIT];  // RULE_02
        src1  = TIMER_MODE_REGISTER[`DTC_T1_SRC_BIT];  // RULE_02
        gate0 = TIMER_MODE_REGISTER[`DTC_T0_GATE_BIT];
        gate1 = TIMER_MODE_REGISTER[`DTC_T1_GATE_BIT];
    end

    // pins
    logic cpin0_lvl, cpin0_fall, cpin1_lvl, cpin1_fall;
    logic gpin0_lvl, gpin1_lvl;

    dtc_pin_sync u_cpin0 (
        .clk   (SYS_CLK),
        .rst   (RST),
        .pin   (TIMER0_COUNT_PIN_IN),
        .level (),
        .fall  (cpin0_fall)
    );
    dtc_pin_sync u_cpin1 (
        .clk   (SYS_CLK),
        .rst   (RST),
        .pin   (TIMER1_COUNT_PIN_IN),
        .level (),
        .fall  (cpin1_fall)
    );
    dtc_pin_sync u_gpin0 (
        .clk   (SYS_CLK),
        .rst   (RST),
        .pin   (GATE_PIN_ZERO),
        .level (gpin0_lvl),
        .fall  ()
    );
    dtc_pin_sync u_gpin1 (
        .clk   (SYS_CLK),
        .rst   (RST),
        .pin   (GATE_PIN_ONE),
        .level (gpin1_lvl),
        .fall  ()
    );

    // shared divide-by-twelve prescaler, free running
    logic [PW-1:0] pre_q, pre_d;
    logic          pre_tick;

    always_comb begin
        pre_tick = (pre_q == PRE_LAST);
        pre_d    = pre_tick ? '0 : pre_q + PW'(1);
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    // count enables
    logic split0;
    logic clk_tick0, clk_tick1;
    logic cnt0, cnt0h, cnt1;

    always_comb begin
        split0    = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
        clk_tick0 = TIMER0_CLOCK_DIVIDE_SELECT | pre_tick; // RULE_03
        clk_tick1 = TIMER1_CLOCK_DIVIDE_SELECT | pre_tick; // RULE_03 RULE_19
        // run bit low means no count, so both bytes hold outside split mode
        cnt0 = TIMER0_RUN_BIT & (~gate0 | gpin0_lvl)
             & (src0 ? cpin0_fall : clk_tick0); // RULE_10 RULE_16 RULE_22
        // split high byte: clock cycles only, started by timer 1 run
        cnt0h = split0 & TIMER1_RUN_BIT & clk_tick0; // RULE_17
        // in split mode timer 1 runs without its run bit, still under its gate, unless in its own mode 3
        cnt1 = (split0 | TIMER1_RUN_BIT) & (~gate1 | gpin1_lvl)
             & (mode1 != dtc_pkg::DTC_MODE_SPLIT)
             & (src1 ? cpin1_fall : clk_tick1); // RULE_10 RULE_15 RULE_18 RULE_19
    end

    // timer 0 bytes
    logic [7:0] t0h_q, t0h_d, t0l_q, t0l_d;
    logic       ovf0, ovf0h;

    always_comb begin
        logic [12:0] sum13;
        logic [15:0] sum16;
        sum13 = {t0h_q, t0l_q[4:0]} + 13'h0001;
        sum16 = {t0h_q, t0l_q} + 16'h0001;
        t0h_d = t0h_q;
        t0l_d = t0l_q;
        ovf0  = 1'b0;
        ovf0h = 1'b0;
        if (cnt0) begin
            unique case (mode0)
                dtc_pkg::DTC_MODE_13BIT: begin
                    // upper three low-byte bits hold their value
                    t0h_d      = sum13[12:5]; // RULE_09
                    t0l_d[4:0] = sum13[4:0];  // RULE_09
                    ovf0       = &{t0h_q, t0l_q[4:0]}; // RULE_11
                end
                dtc_pkg::DTC_MODE_16BIT: begin
                    {t0h_d, t0l_d} = sum16;
                    ovf0           = &{t0h_q, t0l_q}; // RULE_12
                end
                dtc_pkg::DTC_MODE_RELOAD8: begin
                    ovf0  = &t0l_q;
                    t0l_d = ovf0 ? t0h_q : t0l_q + 8'h01; // RULE_13
                end
                dtc_pkg::DTC_MODE_SPLIT: begin
                    ovf0  = &t0l_q; // RULE_16
                    t0l_d = t0l_q + 8'h01;
                end
            endcase
        end
        if (cnt0h) begin
            ovf0h = &t0h_q; // RULE_17
            t0h_d = t0h_q + 8'h01;
        end
        // a software write overrides the count in the same cycle
        if (WRITE_TIMER0_HIGH_BYTE) begin
            t0h_d = WRITE_DATA; // RULE_01
        end
        if (WRITE_TIMER0_LOW_BYTE) begin
            t0l_d = WRITE_DATA; // RULE_01
        end
    end

    // timer 1 bytes
    logic [7:0] t1h_q, t1h_d, t1l_q, t1l_d;
    logic       ovf1;

    always_comb begin
        logic [12:0] sum13;
        logic [15:0] sum16;
        sum13 = {t1h_q, t1l_q[4:0]} + 13'h0001;
        sum16 = {t1h_q, t1l_q} + 16'h0001;
        t1h_d = t1h_q;
        t1l_d = t1l_q;
        ovf1  = 1'b0;
        if (cnt1) begin
            unique case (mode1)
                dtc_pkg::DTC_MODE_13BIT: begin
                    t1h_d      = sum13[12:5]; // RULE_09
                    t1l_d[4:0] = sum13[4:0];  // RULE_09
                    ovf1       = &{t1h_q, t1l_q[4:0]}; // RULE_11
                end
                dtc_pkg::DTC_MODE_16BIT: begin
                    {t1h_d, t1l_d} = sum16;
                    ovf1           = &{t1h_q, t1l_q}; // RULE_12
                end
                dtc_pkg::DTC_MODE_RELOAD8: begin
                    ovf1  = &t1l_q;
                    t1l_d = ovf1 ? t1h_q : t1l_q + 8'h01; // RULE_13
                end
                dtc_pkg::DTC_MODE_SPLIT: begin
                    ovf1 = 1'b0; // RULE_15
                end
            endcase
        end
        if (WRITE_TIMER1_HIGH_BYTE) begin
            t1h_d = WRITE_DATA; // RULE_01
        end
        if (WRITE_TIMER1_LOW_BYTE) begin
            t1l_d = WRITE_DATA; // RULE_01
        end
    end

    // flags, baud tick and toggle outputs
    logic set0, set1;
    logic tf0_q, tf0_d, tf1_q, tf1_d;
    logic baud_q, baud_d;
    logic tog0_q, tog0_d, tog1_q, tog1_d;
    logic oe0_q, oe0_d, oe1_q, oe1_d;

    always_comb begin
        set0 = ovf0;
        // split mode hands timer 1's flag to the timer 0 high byte
        set1 = split0 ? ovf0h : ovf1; // RULE_17 RULE_18
        // hardware set wins over a clear in the same cycle
        tf0_d = set0 | TIMER0_FLAG_SET
              | (tf0_q & ~TIMER0_FLAG_CLEAR & ~TIMER0_SERVICE_ENTRY); // RULE_21
        tf1_d = set1 | TIMER1_FLAG_SET
              | (tf1_q & ~TIMER1_FLAG_CLEAR & ~TIMER1_SERVICE_ENTRY); // RULE_21
        // timer 1 overflow ticks the baud logic even in split mode
        baud_d = ovf1; // RULE_14
        oe0_d  = TIMER0_TOGGLE_OUTPUT_ENABLE & ~src0; // RULE_07
        oe1_d  = TIMER1_TOGGLE_OUTPUT_ENABLE & ~src1; // RULE_07
        // level is parked high while off, so it starts high when enabled
        if (!oe0_d) begin
            tog0_d = `DTC_TOGGLE_RESET; // RULE_06
        end else begin
            tog0_d = tog0_q ^ ovf0; // RULE_05
        end
        if (!oe1_d) begin
            tog1_d = `DTC_TOGGLE_RESET; // RULE_06
        end else begin
            tog1_d = tog1_q ^ ovf1; // RULE_05
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            t0h_q  <= `DTC_BYTE_RESET;
            t0l_q  <= `DTC_BYTE_RESET;
            t1h_q  <= `DTC_BYTE_RESET;
            t1l_q  <= `DTC_BYTE_RESET;
            tf0_q  <= `DTC_FLAG_RESET;
            tf1_q  <= `DTC_FLAG_RESET;
            baud_q <= 1'b0;
            tog0_q <= `DTC_TOGGLE_RESET;
            tog1_q <= `DTC_TOGGLE_RESET;
            oe0_q  <= 1'b0;
            oe1_q  <= 1'b0;
        end else begin
            t0h_q  <= t0h_d;
            t0l_q  <= t0l_d;
            t1h_q  <= t1h_d;
            t1l_q  <= t1l_d;
            tf0_q  <= tf0_d;
            tf1_q  <= tf1_d;
            baud_q <= baud_d;
            tog0_q <= tog0_d;
            tog1_q <= tog1_d;
            oe0_q  <= oe0_d;
            oe1_q  <= oe1_d;
        end
    end

    assign TIMER0_HIGH_BYTE     = t0h_q;
    assign TIMER0_LOW_BYTE      = t0l_q;
    assign TIMER1_HIGH_BYTE     = t1h_q;
    assign TIMER1_LOW_BYTE      = t1l_q;
    assign TIMER0_OVERFLOW_FLAG = tf0_q;
    assign TIMER1_OVERFLOW_FLAG = tf1_q;
    assign TIMER0_IRQ           = tf0_q; // RULE_23
    assign TIMER1_IRQ           = tf1_q; // RULE_23
    assign BAUD_TICK            = baud_q;
    assign TIMER0_COUNT_PIN_OUT = tog0_q;
    assign TIMER0_COUNT_PIN_OE  = oe0_q;
    assign TIMER1_COUNT_PIN_OUT = tog1_q;
    assign TIMER1_COUNT_PIN_OE  = oe1_q;
endmodule

// ===== dtc_timer_props.sv
// dual timer/counter: concurrent checks on the top module ports
// assumes one clock domain and the field layout of the mode register
`timescale 1ns/1ps
module dtc_timer_props (
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       TIMER0_RUN_BIT,
    input wire logic       TIMER0_CLOCK_DIVIDE_SELECT,
    input wire logic [7:0] TIMER_MODE_REGISTER,
    input wire logic       TIMER0_TOGGLE_OUTPUT_ENABLE,
    input wire logic       TIMER0_FLAG_SET,
    input wire logic       TIMER0_SERVICE_ENTRY,
    input wire logic       WRITE_TIMER0_HIGH_BYTE,
    input wire logic       WRITE_TIMER0_LOW_BYTE,
    input wire logic       WRITE_TIMER1_HIGH_BYTE,
    input wire logic       WRITE_TIMER1_LOW_BYTE,
    input wire logic [7:0] TIMER0_HIGH_BYTE,
    input wire logic [7:0] TIMER0_LOW_BYTE,
    input wire logic [7:0] TIMER1_HIGH_BYTE,
    input wire logic [7:0] TIMER1_LOW_BYTE,
    input wire logic       TIMER0_OVERFLOW_FLAG,
    input wire logic       TIMER0_IRQ,
    input wire logic       BAUD_TICK,
    input wire logic       TIMER0_COUNT_PIN_OUT,
    input wire logic       TIMER0_COUNT_PIN_OE,
    input wire logic       TIMER1_COUNT_PIN_OUT,
    input wire logic       TIMER1_COUNT_PIN_OE
);
    logic wr0, wr1, oe0_want;
    assign wr0 = WRITE_TIMER0_HIGH_BYTE | WRITE_TIMER0_LOW_BYTE;
    assign wr1 = WRITE_TIMER1_HIGH_BYTE | WRITE_TIMER1_LOW_BYTE;
    assign oe0_want = TIMER0_TOGGLE_OUTPUT_ENABLE & ~TIMER_MODE_REGISTER[2];
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // timer 0 counting every clock, ungated, no byte writes
    sequence s_t0_fast(logic [1:0] m);
        TIMER_MODE_REGISTER[3:0] == {2'b00, m} && TIMER0_RUN_BIT
            && TIMER0_CLOCK_DIVIDE_SELECT && !wr0;
    endsequence
    a_wrap_sixteen: assert property (s_t0_fast(2'b01)
        ##0 {TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE} == 16'hffff
        |=> {TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE} == 16'h0000 && TIMER0_OVERFLOW_FLAG)
        else $error("sixteen-bit rollover wrong");
    a_wrap_thirteen: assert property (s_t0_fast(2'b00) ##0 TIMER0_HIGH_BYTE == 8'hff
        && TIMER0_LOW_BYTE[4:0] == 5'h1f |=> TIMER0_HIGH_BYTE == 8'h00 && TIMER0_OVERFLOW_FLAG
        && TIMER0_LOW_BYTE == ($past(TIMER0_LOW_BYTE) & 8'he0))
        else $error("thirteen-bit rollover wrong");
    a_reload_eight: assert property (s_t0_fast(2'b10) ##0 TIMER0_LOW_BYTE == 8'hff
        |=> TIMER0_LOW_BYTE == $past(TIMER0_HIGH_BYTE) && $stable(TIMER0_HIGH_BYTE)
        && TIMER0_OVERFLOW_FLAG) else $error("auto reload wrong");
    a_run_holds: assert property (!TIMER0_RUN_BIT && TIMER_MODE_REGISTER[1:0] != 2'b11
        && !wr0 |=> $stable({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}))
        else $error("stopped count moved");
    a_t1_frozen: assert property (TIMER_MODE_REGISTER[5:4] == 2'b11 && !wr1
        |=> $stable({TIMER1_HIGH_BYTE, TIMER1_LOW_BYTE}) && !BAUD_TICK)
        else $error("timer 1 not frozen");
    a_irq_level: assert property (TIMER0_IRQ == TIMER0_OVERFLOW_FLAG)
        else $error("request differs from flag");
    a_soft_set: assert property (TIMER0_FLAG_SET |=> TIMER0_OVERFLOW_FLAG)
        else $error("flag set strobe ignored");
    a_service_clear: assert property (TIMER0_SERVICE_ENTRY && !TIMER0_FLAG_SET
        && !TIMER0_RUN_BIT && TIMER_MODE_REGISTER[1:0] != 2'b11 |=> !TIMER0_OVERFLOW_FLAG)
        else $error("service entry left flag set");
    a_toggle_gate: assert property (1'b1 |=> TIMER0_COUNT_PIN_OE == $past(oe0_want))
        else $error("toggle enable path wrong");
    a_idle_high: assert property (!TIMER0_COUNT_PIN_OE |-> TIMER0_COUNT_PIN_OUT)
        else $error("toggle output not idle high");
    a_toggle_flip: assert property (BAUD_TICK && TIMER1_COUNT_PIN_OE
        && $past(TIMER1_COUNT_PIN_OE) |-> TIMER1_COUNT_PIN_OUT != $past(TIMER1_COUNT_PIN_OUT))
        else $error("toggle output missed overflow");
endmodule
bind dtc_timer dtc_timer_props props (.*);

// ===== dtc_timer_tb.sv
// dual timer/counter: self-checking bench driving strobes and pins
// assumes the checker is bound to the design and a pull-up on count pins
`timescale 1ns/1ps
module dtc_timer_tb;
    logic SYS_CLK, RST, TIMER0_RUN_BIT, TIMER1_RUN_BIT, GATE_PIN_ZERO, GATE_PIN_ONE;
    logic TIMER0_CLOCK_DIVIDE_SELECT, TIMER1_CLOCK_DIVIDE_SELECT;
    logic TIMER0_TOGGLE_OUTPUT_ENABLE, TIMER1_TOGGLE_OUTPUT_ENABLE;
    logic [7:0] TIMER_MODE_REGISTER, WRITE_DATA;
    logic [7:0] TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE, TIMER1_HIGH_BYTE, TIMER1_LOW_BYTE;
    logic WRITE_TIMER0_HIGH_BYTE, WRITE_TIMER0_LOW_BYTE, WRITE_TIMER1_HIGH_BYTE;
    logic WRITE_TIMER1_LOW_BYTE, TIMER0_FLAG_SET, TIMER0_FLAG_CLEAR, TIMER0_SERVICE_ENTRY;
    logic TIMER1_FLAG_SET, TIMER1_FLAG_CLEAR, TIMER1_SERVICE_ENTRY, BAUD_TICK;
    logic TIMER0_COUNT_PIN_IN, TIMER1_COUNT_PIN_IN, TIMER0_IRQ, TIMER1_IRQ;
    logic TIMER0_OVERFLOW_FLAG, TIMER1_OVERFLOW_FLAG, TIMER0_COUNT_PIN_OUT;
    logic TIMER0_COUNT_PIN_OE, TIMER1_COUNT_PIN_OUT, TIMER1_COUNT_PIN_OE;
    logic [3:0] wr;
    logic [5:0] fo;
    logic       prev;
    logic [15:0] snap;
    int mismatches, comparisons, cycles, ticks, flips;
    assign {WRITE_TIMER1_HIGH_BYTE, WRITE_TIMER1_LOW_BYTE} = wr[3:2];
    assign {WRITE_TIMER0_HIGH_BYTE, WRITE_TIMER0_LOW_BYTE} = wr[1:0];
    assign {TIMER1_SERVICE_ENTRY, TIMER1_FLAG_CLEAR, TIMER1_FLAG_SET} = fo[5:3];
    assign {TIMER0_SERVICE_ENTRY, TIMER0_FLAG_CLEAR, TIMER0_FLAG_SET} = fo[2:0];
    dtc_timer uut (.*);
    dtc_pin_model pm0 (.clk(SYS_CLK), .dev_out(TIMER0_COUNT_PIN_OUT),
                       .dev_oe(TIMER0_COUNT_PIN_OE), .pin(TIMER0_COUNT_PIN_IN));
    dtc_pin_model pm1 (.clk(SYS_CLK), .dev_out(TIMER1_COUNT_PIN_OUT),
                       .dev_oe(TIMER1_COUNT_PIN_OE), .pin(TIMER1_COUNT_PIN_IN));
    initial begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // hang guard well above the few hundred cycles the sequence needs
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_byte(input logic [3:0] sel, input logic [7:0] d);
        @(posedge SYS_CLK);
        wr <= sel;
        WRITE_DATA <= d;
        @(posedge SYS_CLK);
        wr <= 4'h0;
    endtask
    task automatic flag_op(input logic [5:0] sel);
        @(posedge SYS_CLK);
        fo <= sel;
        @(posedge SYS_CLK);
        fo <= 6'h00;
        #1;
    endtask
    // exactly n counting edges see the run bit high
    task automatic run0(input int n);
        @(posedge SYS_CLK);
        TIMER0_RUN_BIT <= 1'b1;
        repeat (n) @(posedge SYS_CLK);
        TIMER0_RUN_BIT <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic mode0(input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo);
        @(posedge SYS_CLK);
        TIMER_MODE_REGISTER <= m;
        wr_byte(4'b0010, hi);
        wr_byte(4'b0001, lo);
        flag_op(6'b000100);
    endtask
    initial begin
        {RST, TIMER0_CLOCK_DIVIDE_SELECT, TIMER1_CLOCK_DIVIDE_SELECT} = 3'b111;
        {TIMER0_RUN_BIT, TIMER1_RUN_BIT, GATE_PIN_ZERO, GATE_PIN_ONE} = 4'h0;
        {TIMER0_TOGGLE_OUTPUT_ENABLE, TIMER1_TOGGLE_OUTPUT_ENABLE} = 2'b00;
        {TIMER_MODE_REGISTER, WRITE_DATA, wr, fo} = 26'h0;
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        #1;
        chk({TIMER0_HIGH_BYTE, TIMER1_LOW_BYTE}, 16'h0000);
        chk({13'h0, TIMER0_COUNT_PIN_OUT, TIMER0_COUNT_PIN_OE, TIMER1_IRQ}, 16'h0004);
        mode0(8'h01, 8'hff, 8'hfe);
        run0(2);
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h0000);
        chk({14'h0, TIMER0_OVERFLOW_FLAG, TIMER0_IRQ}, 16'h0003);
        repeat (5) @(posedge SYS_CLK);
        #1;
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h0000);
        chk({15'h0, TIMER0_OVERFLOW_FLAG}, 16'h0001);
        flag_op(6'b000001);
        chk({15'h0, TIMER0_OVERFLOW_FLAG}, 16'h0001);
        flag_op(6'b000010);
        chk({15'h0, TIMER0_OVERFLOW_FLAG}, 16'h0000);
        mode0(8'h00, 8'hff, 8'hfe);
        run0(2);
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h00e0);
        chk({15'h0, TIMER0_OVERFLOW_FLAG}, 16'h0001);
        mode0(8'h02, 8'h80, 8'hfe);
        run0(3);
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h8081);
        chk({15'h0, TIMER0_OVERFLOW_FLAG}, 16'h0001);
        @(posedge SYS_CLK);
        TIMER0_CLOCK_DIVIDE_SELECT <= 1'b0;
        mode0(8'h01, 8'h00, 8'h00);
        run0(120);
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h000a);
        @(posedge SYS_CLK);
        TIMER0_CLOCK_DIVIDE_SELECT <= 1'b1;
        mode0(8'h09, 8'h00, 8'h00);
        @(posedge SYS_CLK);
        TIMER0_RUN_BIT <= 1'b1;
        repeat (10) @(posedge SYS_CLK);
        GATE_PIN_ZERO <= 1'b1;
        repeat (30) @(posedge SYS_CLK);
        GATE_PIN_ZERO <= 1'b0;
        run0(6);
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h001e);
        @(posedge SYS_CLK);
        TIMER0_TOGGLE_OUTPUT_ENABLE <= 1'b1;
        mode0(8'h05, 8'h00, 8'h00);
        @(posedge SYS_CLK);
        TIMER0_RUN_BIT <= 1'b1;
        pm0.falls(5);
        run0(6);
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h0005);
        chk({15'h0, TIMER0_COUNT_PIN_OE}, 16'h0000);
        @(posedge SYS_CLK);
        TIMER1_TOGGLE_OUTPUT_ENABLE <= 1'b1;
        TIMER_MODE_REGISTER <= 8'h20;
        wr_byte(4'b1000, 8'hfe);
        wr_byte(4'b0100, 8'hfe);
        TIMER1_RUN_BIT <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        #1;
        prev = TIMER1_COUNT_PIN_IN;
        {ticks, flips} = 64'h0;
        repeat (40) begin
            @(posedge SYS_CLK);
            #1;
            ticks += int'(BAUD_TICK);
            flips += int'(TIMER1_COUNT_PIN_IN != prev);
            prev = TIMER1_COUNT_PIN_IN;
        end
        chk(ticks[15:0], 16'h0014);
        chk(flips[15:0], 16'h0014);
        chk({14'h0, TIMER1_OVERFLOW_FLAG, TIMER1_IRQ}, 16'h0003);
        @(posedge SYS_CLK);
        TIMER1_RUN_BIT <= 1'b0;
        TIMER1_TOGGLE_OUTPUT_ENABLE <= 1'b0;
        mode0(8'h13, 8'hfe, 8'h05);
        flag_op(6'b010000);
        @(posedge SYS_CLK);
        TIMER1_RUN_BIT <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        TIMER1_RUN_BIT <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
        chk({TIMER0_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h0005);
        chk({14'h0, TIMER1_OVERFLOW_FLAG, TIMER1_IRQ}, 16'h0003);
        flag_op(6'b010000);
        wr_byte(4'b0100, 8'hf0);
        wr_byte(4'b1000, 8'hff);
        repeat (40) @(posedge SYS_CLK);
        #1;
        chk({TIMER1_HIGH_BYTE, TIMER0_LOW_BYTE}, 16'h0005);
        chk({15'h0, TIMER1_OVERFLOW_FLAG}, 16'h0000);
        @(posedge SYS_CLK);
        TIMER_MODE_REGISTER <= 8'h33;
        repeat (3) @(posedge SYS_CLK);
        #1;
        snap = {TIMER1_HIGH_BYTE, TIMER1_LOW_BYTE};
        repeat (10) @(posedge SYS_CLK);
        #1;
        chk({TIMER1_HIGH_BYTE, TIMER1_LOW_BYTE}, snap);
        tally_and_finish;
    end
endmodule
